// [logic/tws_defs.svh]
// Constants for the timer, watchdog, interrupt and sleep unit
// Notes on behaviour
// - Timer mode: tick count increments each instruction cycle without prescaler.
// - Writing tick count suppresses counting for the next two instruction cycles.
// - Counter mode: tick count increments on selected external count pin edges.
// - Watchdog runs in sleep too; expiry resets device, clears expired flag.
// - Clearing watchdog enable stops the watchdog.
// - Watchdog expires after 18 ms, times prescaler ratio up to 1:128.
// - Watchdog clear zeroes watchdog, loads its assigned prescaler with all ones; no reset follows.
// - Power-down also restarts watchdog and its assigned prescaler.
// - One 8-bit down prescaler serves timer or watchdog, chosen by target bit.
// - Tick count writes clear timer prescaler; prescaler is not software visible.
// - Only reset_n and a prescaler clear load the prescaler with all ones; a watchdog reset leaves it as it is.
// - Global enable passes unmasked requests; source enables are independent.
// - Taken request clears global enable and vectors to 008h.
// - Return from handler sets global enable again.
// - Flags except port change set unmasked; flag reads return flags AND enables.
// - Software interrupt instruction vectors to 002h.
// - Selected edge on external request pin sets external flag.
// - Tick count wrap FFh to 00h sets overflow flag.
// - Eligible port B pin change sets port change flag.
// - Power-down clears powerdown flag, sets expired flag, zeroes watchdog.
// - Enabled external or port change request wakes; vector only if global set.
// - Wake-up waits 18 ms plus 128 instruction cycles before resuming.
// - Ratio code gives timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Prescaler target 1 selects watchdog, 0 selects timer.
// - Count edge select 1 counts falling edges, 0 rising edges.
// - Edge select 1 triggers on rising edges, 0 on falling edges.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
// ==========
// Register byte offsets
`define TWS_OFF_TICK 8'h00
`define TWS_OFF_OPT 8'h04
`define TWS_OFF_STAT 8'h08
`define TWS_OFF_PCTL 8'h0C
`define TWS_OFF_WAKE 8'h10
`define TWS_OFF_MASK 8'h14
`define TWS_OFF_FLAG 8'h18
`define TWS_OFF_PDIR 8'h1C
`define TWS_OFF_PDAT 8'h20
`define TWS_OFF_CMD 8'h24
// ==========
// Reset values
`define TWS_OPT_RST 7'h3F
`define TWS_PCTL_RST 2'h2
`define TWS_WAKE_RST 8'h00
`define TWS_MASK_RST 8'h00
`define TWS_FLAG_RST 3'h0
`define TWS_PDIR_RST 8'hFF
`define TWS_PS_ONES 8'hFF
`define TWS_MASK_IMPL 8'h87
`define TWS_TICK_MAX 8'hFF
// ==========
// Field positions
`define TWS_OPT_EXT_EDGE 6
`define TWS_OPT_SRC 5
`define TWS_OPT_CEDGE 4
`define TWS_OPT_PSA 3
`define TWS_OPT_RATIO 2:0
`define TWS_PCTL_WDE 1
`define TWS_PCTL_EIS 0
`define TWS_IRQ_GIE 7
`define TWS_IRQ_EXT 2
`define TWS_IRQ_PC 1
`define TWS_IRQ_OVF 0
`define TWS_CMD_WDCLR 0
`define TWS_CMD_SLEEP 1
`define TWS_CMD_RFH 2
`define TWS_CMD_SWI 3
// ==========
// Vectors and timing
`define TWS_VEC_IRQ 12'h008
`define TWS_VEC_SWI 12'h002
`define TWS_CLK_NS 10
`define TWS_WDT_NS 18000000
`define TWS_WDT_CYC (`TWS_WDT_NS / `TWS_CLK_NS)
`define TWS_OST_CYC 128
`define TWS_WAKE_CYC (`TWS_WDT_CYC + `TWS_OST_CYC)
`define TWS_INHIBIT 2'd2
`define TWS_DLY_W 21
`endif

// [logic/tws_pkg.sv]
// Types shared by the timer, watchdog, interrupt and sleep unit
package tws_pkg;
  typedef enum logic [1:0] {TWS_RUN, TWS_SLEEP, TWS_WAKE} tws_pwr_e;
endpackage : tws_pkg

// [logic/tws_ps_if.sv]
// Link between the unit and its shared prescaler
`timescale 1ns/10ps
interface tws_ps_if;
  logic in_pulse;
  logic clear;
  logic to_wdt;
  logic [2:0] ratio;
  logic out_pulse;
  modport ctl (output in_pulse, output clear, output to_wdt, output ratio, input out_pulse);
  modport ps (input in_pulse, input clear, input to_wdt, input ratio, output out_pulse);
endinterface : tws_ps_if

// [logic/tws_prescaler.sv]
// Shared 8-bit down-counting prescaler
`timescale 1ns/10ps
`include "tws_defs.svh"
module tws_prescaler (
  input wire logic core_clk, // Instruction clock
  input wire logic reset_n, // Async reset, active low
  tws_ps_if.ps ps // Control and output pulse
);
  logic [7:0] cnt_reg;
  // Timer divides by 2^(code+1), watchdog by 2^code
  wire [3:0] shift = ps.to_wdt ? {1'b0, ps.ratio} : 4'({1'b0, ps.ratio} + 4'h1);
  wire [8:0] span = 9'(9'h001 << shift);
  wire [7:0] low_mask = 8'(span - 9'h001);
  assign ps.out_pulse = ps.in_pulse && !ps.clear && ((cnt_reg & low_mask) == 8'h00);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= `TWS_PS_ONES;
    end else if (ps.clear) begin
      cnt_reg <= `TWS_PS_ONES;
    end else if (ps.in_pulse) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  a_ps_clear_ones: assert property (
    @(posedge core_clk) disable iff (!reset_n) ps.clear |=> cnt_reg == `TWS_PS_ONES)
    else $error("prescaler not all ones after clear");
endmodule : tws_prescaler

// [logic/tws_watchdog.sv]
// Watchdog base period counter on the instruction clock
`timescale 1ns/10ps
`include "tws_defs.svh"
module tws_watchdog #(
  parameter int unsigned PERIOD_CYC = `TWS_WDT_CYC // Base period in clocks
) (
  input wire logic core_clk, // Instruction clock
  input wire logic reset_n, // Async reset, active low
  input wire logic enable, // Watchdog enable
  input wire logic clear, // Zero the counter
  output logic base_pulse // One pulse per base period
);
  logic [`TWS_DLY_W-1:0] cnt_reg;
  wire at_end = cnt_reg == `TWS_DLY_W'(PERIOD_CYC - 1);
  // Kept running in sleep: only the enable bit stops it
  assign base_pulse = enable && !clear && at_end;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (clear || (enable && at_end)) begin
      cnt_reg <= '0;
    end else if (enable) begin
      cnt_reg <= cnt_reg + `TWS_DLY_W'(1);
    end
  end

  a_wdt_stopped: assert property (
    @(posedge core_clk) disable iff (!reset_n) !enable && !clear |=> $stable(cnt_reg))
    else $error("watchdog counted while disabled");
  a_wdt_cleared: assert property (
    @(posedge core_clk) disable iff (!reset_n) clear |=> cnt_reg == '0 && !base_pulse)
    else $error("watchdog not zeroed by clear");
endmodule : tws_watchdog

// [logic/tws_top.sv]
// Timer, watchdog, interrupt and sleep unit with AHB-Lite registers
`timescale 1ns/10ps
`include "tws_defs.svh"
module tws_top #(
  parameter int unsigned WDT_PERIOD_CYC = `TWS_WDT_CYC, // Watchdog base period
  parameter int unsigned WAKE_DELAY_CYC = `TWS_WAKE_CYC // Wake-up hold-off
) (
  input wire logic core_clk, // Instruction clock, 100 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic ext_count_pin, // External count input
  input wire logic [7:0] port_b_pins, // Port B input levels
  output logic vector_req, // Fetch from vector, one pulse
  output logic [11:0] vector_addr, // Vector address
  output logic osc_stop, // Oscillator driver off
  output logic cpu_hold, // Core and pins held
  output logic wdt_reset // Watchdog reset pulse
);
  // ==========
  // Bus slave
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic hit_reg;
  logic [7:0] addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic hresp_reg;
  logic [7:0] rd_byte;

  wire addr_phase = hsel && hready && htrans[1];
  wire addr_hit = haddr[31:8] == 24'h00_0000 && haddr[1:0] == 2'b00;

  // Reads take one wait state so a write just before is seen
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hit_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      hreadyout_reg <= !(addr_phase && !hwrite);
      hresp_reg <= 1'b0;
      if (addr_phase) begin
        addr_reg <= haddr[7:0];
        hit_reg <= addr_hit;
      end
      if (rd_pend_reg) begin
        hrdata_reg <= hit_reg ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;

  wire wr_ok = wr_pend_reg && hit_reg;
  wire rd_ok = rd_pend_reg && hit_reg;
  wire [7:0] wdat = hwdata[7:0];
  wire wr_tick = wr_ok && addr_reg == `TWS_OFF_TICK;
  wire wr_opt = wr_ok && addr_reg == `TWS_OFF_OPT;
  wire wr_pctl = wr_ok && addr_reg == `TWS_OFF_PCTL;
  wire wr_wake = wr_ok && addr_reg == `TWS_OFF_WAKE;
  wire wr_mask = wr_ok && addr_reg == `TWS_OFF_MASK;
  wire wr_flag = wr_ok && addr_reg == `TWS_OFF_FLAG;
  wire wr_pdir = wr_ok && addr_reg == `TWS_OFF_PDIR;
  wire wr_cmd = wr_ok && addr_reg == `TWS_OFF_CMD;
  wire pdat_acc = (wr_ok || rd_ok) && addr_reg == `TWS_OFF_PDAT;

  // ==========
  // Control registers
  logic [6:0] option_reg;
  logic [1:0] power_ctrl_reg;
  logic [7:0] wake_enable_reg;
  logic [7:0] port_b_dir_reg;
  logic [7:0] irq_mask_reg;
  logic [2:0] irq_flag_reg;
  logic [7:0] tick_count_reg;
  logic wdt_expired_n_reg;
  logic powerdown_flag_n_reg;
  tws_pkg::tws_pwr_e pwr_reg;
  tws_pkg::tws_pwr_e pwr_next;
  logic wdt_expire;

  wire opt_psa = option_reg[`TWS_OPT_PSA];
  wire eis = power_ctrl_reg[`TWS_PCTL_EIS];
  wire run = pwr_reg == tws_pkg::TWS_RUN;
  wire cmd_wdclr = wr_cmd && wdat[`TWS_CMD_WDCLR];
  wire cmd_sleep = wr_cmd && wdat[`TWS_CMD_SLEEP] && run;
  wire cmd_rfh = wr_cmd && wdat[`TWS_CMD_RFH];
  wire cmd_swi = wr_cmd && wdat[`TWS_CMD_SWI];

  always_comb begin
    case (addr_reg)
      `TWS_OFF_TICK: rd_byte = tick_count_reg;
      `TWS_OFF_OPT: rd_byte = {1'b0, option_reg};
      `TWS_OFF_STAT: rd_byte = {3'b000, wdt_expired_n_reg, powerdown_flag_n_reg, 3'b000};
      `TWS_OFF_PCTL: rd_byte = {power_ctrl_reg, 6'h00};
      `TWS_OFF_WAKE: rd_byte = wake_enable_reg;
      `TWS_OFF_MASK: rd_byte = irq_mask_reg;
      `TWS_OFF_FLAG: rd_byte = {5'h00, irq_flag_reg & irq_mask_reg[2:0]};
      `TWS_OFF_PDIR: rd_byte = port_b_dir_reg;
      `TWS_OFF_PDAT: rd_byte = port_b_pins;
      default: rd_byte = 8'h00;
    endcase
  end

  // Watchdog expiry is a device reset for everything it governs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      option_reg <= `TWS_OPT_RST;
      power_ctrl_reg <= `TWS_PCTL_RST;
      wake_enable_reg <= `TWS_WAKE_RST;
      port_b_dir_reg <= `TWS_PDIR_RST;
    end else if (wdt_expire) begin
      option_reg <= `TWS_OPT_RST;
      power_ctrl_reg <= `TWS_PCTL_RST;
      wake_enable_reg <= `TWS_WAKE_RST;
      port_b_dir_reg <= `TWS_PDIR_RST;
    end else begin
      if (wr_opt) begin
        option_reg <= wdat[6:0];
      end
      if (wr_pctl) begin
        power_ctrl_reg <= wdat[7:6];
      end
      if (wr_wake) begin
        wake_enable_reg <= wdat;
      end
      if (wr_pdir) begin
        port_b_dir_reg <= wdat;
      end
    end
  end

  // Reset-cause flags survive the watchdog reset they report
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_expired_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else if (wdt_expire) begin
      wdt_expired_n_reg <= 1'b0;
    end else if (cmd_sleep) begin
      wdt_expired_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b0;
    end else if (cmd_wdclr) begin
      wdt_expired_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end
  end

  // ==========
  // Tick counter and prescaler
  tws_ps_if ps_bus ();
  logic ext_prev_reg;
  logic [1:0] inhibit_reg;
  logic wdt_base;

  wire ext_rise = ext_count_pin && !ext_prev_reg;
  wire ext_fall = !ext_count_pin && ext_prev_reg;
  wire cnt_edge = option_reg[`TWS_OPT_CEDGE] ? ext_fall : ext_rise;
  wire src_pulse = option_reg[`TWS_OPT_SRC] ? cnt_edge : 1'b1;
  wire tick_src = opt_psa ? src_pulse : ps_bus.out_pulse;
  // A write in the same cycle wins over the increment, so no false wrap
  wire tick_inc = tick_src && run && inhibit_reg == 2'd0 && !wr_tick;
  wire tick_ovf = tick_inc && tick_count_reg == `TWS_TICK_MAX;

  assign ps_bus.to_wdt = opt_psa;
  assign ps_bus.ratio = option_reg[`TWS_OPT_RATIO];
  assign ps_bus.in_pulse = opt_psa ? wdt_base : src_pulse && run;
  assign ps_bus.clear = opt_psa ? (cmd_wdclr || cmd_sleep) : wr_tick;
  assign wdt_expire = opt_psa ? ps_bus.out_pulse : wdt_base;

  tws_prescaler u_ps (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ps(ps_bus.ps)
  );

  tws_watchdog #(
    .PERIOD_CYC(WDT_PERIOD_CYC)
  ) u_wdt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(power_ctrl_reg[`TWS_PCTL_WDE]),
    .clear(cmd_wdclr || cmd_sleep),
    .base_pulse(wdt_base)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_reg <= 1'b0;
      inhibit_reg <= 2'd0;
      tick_count_reg <= 8'h00;
    end else begin
      ext_prev_reg <= ext_count_pin;
      if (wr_tick) begin
        tick_count_reg <= wdat;
        inhibit_reg <= `TWS_INHIBIT;
      end else begin
        if (tick_inc) begin
          tick_count_reg <= tick_count_reg + 8'h01;
        end
        if (inhibit_reg != 2'd0 && run) begin
          inhibit_reg <= inhibit_reg - 2'd1;
        end
      end
    end
  end

  // ==========
  // Request flags
  logic pb0_prev_reg;
  logic [7:0] pb_ref_reg;
  logic [7:0] pc_diff;

  wire pb0_rise = port_b_pins[0] && !pb0_prev_reg;
  wire pb0_fall = !port_b_pins[0] && pb0_prev_reg;
  wire ext_edge = option_reg[`TWS_OPT_EXT_EDGE] ? pb0_rise : pb0_fall;
  wire ext_valid = eis && ext_edge;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pc
      wire excl = (gi == 0) ? eis : 1'b0;
      assign pc_diff[gi] = wake_enable_reg[gi] && port_b_dir_reg[gi] && !excl &&
                           (port_b_pins[gi] != pb_ref_reg[gi]);
    end
  endgenerate

  wire pc_set = (|pc_diff) && irq_mask_reg[`TWS_IRQ_PC];
  wire [2:0] flag_set = {ext_valid, pc_set, tick_ovf};
  wire [2:0] flag_kept = wr_flag ? wdat[2:0] : irq_flag_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pb0_prev_reg <= 1'b0;
      pb_ref_reg <= 8'h00;
      irq_flag_reg <= `TWS_FLAG_RST;
    end else begin
      pb0_prev_reg <= port_b_pins[0];
      if (pdat_acc) begin
        pb_ref_reg <= port_b_pins;
      end
      if (wdt_expire) begin
        irq_flag_reg <= `TWS_FLAG_RST;
      end else begin
        irq_flag_reg <= flag_set | flag_kept; // Set beats a same-cycle clear
      end
    end
  end

  // ==========
  // Global enable and vectoring
  logic swi_pend_reg;
  logic vector_req_reg;
  logic [11:0] vector_addr_reg;

  wire irq_pending = |(irq_flag_reg & irq_mask_reg[2:0]);
  wire irq_take = run && irq_mask_reg[`TWS_IRQ_GIE] && irq_pending;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= `TWS_MASK_RST;
    end else if (wdt_expire) begin
      irq_mask_reg <= `TWS_MASK_RST;
    end else begin
      if (wr_mask) begin
        irq_mask_reg <= wdat & `TWS_MASK_IMPL;
      end
      if (cmd_rfh) begin
        irq_mask_reg[`TWS_IRQ_GIE] <= 1'b1;
      end
      if (irq_take) begin
        irq_mask_reg[`TWS_IRQ_GIE] <= 1'b0;
      end
    end
  end

  // Hardware request goes first; a software request waits one turn
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      swi_pend_reg <= 1'b0;
      vector_req_reg <= 1'b0;
      vector_addr_reg <= 12'h000;
    end else if (wdt_expire) begin
      swi_pend_reg <= 1'b0;
      vector_req_reg <= 1'b0;
    end else begin
      vector_req_reg <= 1'b0;
      if (cmd_swi) begin
        swi_pend_reg <= 1'b1;
      end
      if (irq_take) begin
        vector_req_reg <= 1'b1;
        vector_addr_reg <= `TWS_VEC_IRQ;
      end else if (swi_pend_reg && run) begin
        vector_req_reg <= 1'b1;
        vector_addr_reg <= `TWS_VEC_SWI;
        swi_pend_reg <= cmd_swi;
      end
    end
  end

  assign vector_req = vector_req_reg;
  assign vector_addr = vector_addr_reg;

  // ==========
  // Power-down sequencing
  logic [`TWS_DLY_W-1:0] wake_cnt_reg;
  logic osc_stop_reg;
  logic cpu_hold_reg;
  logic wdt_reset_reg;

  wire wake_req = (irq_flag_reg[`TWS_IRQ_EXT] && irq_mask_reg[`TWS_IRQ_EXT]) ||
                  (irq_flag_reg[`TWS_IRQ_PC] && irq_mask_reg[`TWS_IRQ_PC]);

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      tws_pkg::TWS_RUN: begin
        if (cmd_sleep) begin
          pwr_next = tws_pkg::TWS_SLEEP;
        end
      end
      tws_pkg::TWS_SLEEP: begin
        if (wake_req) begin
          pwr_next = tws_pkg::TWS_WAKE;
        end
      end
      tws_pkg::TWS_WAKE: begin
        if (wake_cnt_reg == '0) begin
          pwr_next = tws_pkg::TWS_RUN;
        end
      end
      default: pwr_next = tws_pkg::TWS_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_reg <= tws_pkg::TWS_RUN;
      wake_cnt_reg <= '0;
      osc_stop_reg <= 1'b0;
      cpu_hold_reg <= 1'b0;
      wdt_reset_reg <= 1'b0;
    end else begin
      pwr_reg <= wdt_expire ? tws_pkg::TWS_RUN : pwr_next;
      osc_stop_reg <= !wdt_expire && pwr_next == tws_pkg::TWS_SLEEP;
      cpu_hold_reg <= !wdt_expire && pwr_next != tws_pkg::TWS_RUN;
      wdt_reset_reg <= wdt_expire;
      if (pwr_reg == tws_pkg::TWS_SLEEP) begin
        wake_cnt_reg <= `TWS_DLY_W'(WAKE_DELAY_CYC - 1);
      end else if (wake_cnt_reg != '0) begin
        wake_cnt_reg <= wake_cnt_reg - `TWS_DLY_W'(1);
      end
    end
  end

  assign osc_stop = osc_stop_reg;
  assign cpu_hold = cpu_hold_reg;
  assign wdt_reset = wdt_reset_reg;

  // ==========
  // Checks
  a_tick_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n) wr_tick |=> !tick_inc [*2])
    else $error("tick count moved within two cycles of a write");
  a_ovf_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tick_ovf && !wdt_expire |=> irq_flag_reg[`TWS_IRQ_OVF] && tick_count_reg == 8'h00)
    else $error("wrap did not set overflow flag");
  a_irq_vector: assert property (
    @(posedge core_clk) disable iff (!reset_n) irq_take && !wdt_expire |=>
    vector_req && vector_addr == `TWS_VEC_IRQ && !irq_mask_reg[`TWS_IRQ_GIE])
    else $error("request not vectored to 008h");
  a_rfh_global: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmd_rfh && !irq_take && !wdt_expire |=> irq_mask_reg[`TWS_IRQ_GIE])
    else $error("return did not set global enable");
  a_sleep_flags: assert property (
    @(posedge core_clk) disable iff (!reset_n) cmd_sleep && !wdt_expire |=>
    !powerdown_flag_n_reg && wdt_expired_n_reg && osc_stop && cpu_hold)
    else $error("sleep entry flags wrong");
  a_wdt_reset: assert property (
    @(posedge core_clk) disable iff (!reset_n) wdt_expire |=>
    wdt_reset && !wdt_expired_n_reg && irq_mask_reg == `TWS_MASK_RST ##1 !wdt_reset)
    else $error("watchdog expiry did not reset");
  a_flag_read: assert property (
    @(posedge core_clk) disable iff (!reset_n) rd_ok && addr_reg == `TWS_OFF_FLAG |=>
    hrdata[2:0] == ($past(irq_flag_reg) & $past(irq_mask_reg[2:0])) && hreadyout)
    else $error("flag read not masked");
  a_ext_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ext_valid && !wdt_expire |=> irq_flag_reg[`TWS_IRQ_EXT])
    else $error("external edge lost");
  a_wake_start: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    pwr_reg == tws_pkg::TWS_SLEEP && wake_req && !wdt_expire |=>
    pwr_reg == tws_pkg::TWS_WAKE && !osc_stop && cpu_hold)
    else $error("enabled request did not wake");
endmodule : tws_top

// [test/tws_pins.sv]
// Model of the external count pin and port B inputs
`timescale 1ns/10ps
module tws_pins (
  input wire logic core_clk, // Instruction clock
  input wire logic tog, // Flip the count pin
  input wire logic [7:0] pb_set, // Next port B levels
  output logic ext_count_pin, // External count pin
  output logic [7:0] port_b_pins // Port B levels
);
  initial begin
    ext_count_pin = 1'b0;
    port_b_pins = 8'h00;
  end
  // Pins move just after an edge, as a synchronous source would
  always @(posedge core_clk) begin
    if (tog) begin
      ext_count_pin <= ~ext_count_pin;
    end
    port_b_pins <= pb_set;
  end
endmodule : tws_pins

// [test/test_tws_top.sv]
// Self-checking bench for the timer, watchdog, interrupt and sleep unit
`timescale 1ns/10ps
module test_tws_top;
  localparam int WDT = 64;
  localparam int WAKE = 20;
  logic core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, tog = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, vector_req, osc_stop, cpu_hold, wdt_reset, ext_count_pin;
  logic [11:0] vector_addr;
  logic [7:0] port_b_pins, pb_set = 0;
  int num_errors = 0, checks = 0, wdt_n = 0;
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) if (wdt_reset === 1'b1) wdt_n++;
  tws_pins PTN (.core_clk(core_clk), .tog(tog), .pb_set(pb_set),
    .ext_count_pin(ext_count_pin), .port_b_pins(port_b_pins));
  tws_top #(.WDT_PERIOD_CYC(WDT), .WAKE_DELAY_CYC(WAKE)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ext_count_pin(ext_count_pin),
    .port_b_pins(port_b_pins), .vector_req(vector_req), .vector_addr(vector_addr),
    .osc_stop(osc_stop), .cpu_hold(cpu_hold), .wdt_reset(wdt_reset));
  // ==========
  // Shared tasks
  task complete_run;
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function logic pick(input int s);
    case (s)
      0: pick = hreadyout;
      1: pick = vector_req;
      2: pick = wdt_reset;
      3: pick = ~cpu_hold;
      default: pick = ~osc_stop;
    endcase
  endfunction : pick
  // Looks at negedges: the level seen there is what the next rising edge samples
  task wfor(input int s, output int n);
    n = 0;
    @(negedge core_clk);
    while (pick(s) !== 1'b1 && n < 900) begin
      @(negedge core_clk);
      n++;
    end
    rv = hrdata;
    if (n >= 900) begin
      num_errors++;
      complete_run;
    end
  endtask : wfor
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wfor(0, n);
    @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wfor(0, n);
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rv);
  endtask : rc
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // ==========
  // Scenarios
  task t_reset;
    rc("opt", 8'h04, 32'h3F);
    rc("stat", 8'h08, 32'h18);
    rc("pctl", 8'h0C, 32'h80);
    rc("pdir", 8'h1C, 32'hFF);
    rc("mask", 8'h14, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : t_reset
  task t_timer;
    logic [7:0] r0;
    wr(8'h0C, 32'h0);
    for (int c = 0; c < 2; c++) begin
      wr(8'h04, c ? 32'h0 : 32'h8);
      xfer(1'b0, 8'h00, 32'h0);
      r0 = rv[7:0];
      xfer(1'b0, 8'h14, 32'h0);
      rc("tick_step", 8'h00, {24'h0, r0 + (c ? 8'h3 : 8'h6)});
    end
  endtask : t_timer
  task t_count;
    logic [7:0] r0;
    for (int e = 0; e < 2; e++) begin
      wr(8'h04, e ? 32'h38 : 32'h28);
      for (int k = 0; k < 2; k++) begin
        xfer(1'b0, 8'h00, 32'h0);
        r0 = rv[7:0];
        @(posedge core_clk);
        tog <= 1'b1;
        @(posedge core_clk);
        tog <= 1'b0;
        cyc(6);
        rc("count_edge", 8'h00, {24'h0, r0 + (e == k)});
      end
    end
  endtask : t_count
  task t_irq;
    int n;
    wr(8'h04, 32'h08);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'hFD);
    cyc(10);
    rc("flag_and", 8'h18, 32'h0);
    wr(8'h14, 32'h01);
    rc("flag_ovf", 8'h18, 32'h1);
    wr(8'h14, 32'h81);
    wfor(1, n);
    chk("vec_hw", 32'h008, {20'h0_0000, vector_addr});
    rc("gie_off", 8'h14, 32'h01);
    wr(8'h18, 32'h0);
    wr(8'h24, 32'h4);
    rc("gie_on", 8'h14, 32'h81);
    wr(8'h14, 32'h0);
    wr(8'h24, 32'h8);
    wfor(1, n);
    chk("vec_sw", 32'h002, {20'h0_0000, vector_addr});
  endtask : t_irq
  task t_sleep;
    int n;
    wr(8'h0C, 32'h40);
    wr(8'h04, 32'h7F);
    wr(8'h14, 32'h04);
    wr(8'h24, 32'h2);
    cyc(2);
    @(negedge core_clk);
    chk("sleep_out", 32'h3, {30'h0, osc_stop, cpu_hold});
    rc("stat_sleep", 8'h08, 32'h10);
    @(posedge core_clk);
    pb_set <= 8'h01;
    wfor(4, n);
    wfor(3, n);
    // The wait does not count the negedge it starts on
    chk("wake_delay", WAKE, n + 1);
    rc("flag_ext", 8'h18, 32'h4);
    wr(8'h14, 32'h0);
  endtask : t_sleep
  task t_pchg;
    wr(8'h10, 32'h03);
    rc("pdat", 8'h20, 32'h01);
    wr(8'h14, 32'h02);
    @(posedge core_clk);
    pb_set <= 8'h00;
    cyc(4);
    rc("pc_pin0", 8'h18, 32'h0);
    @(posedge core_clk);
    pb_set <= 8'h02;
    cyc(4);
    rc("pc_pin1", 8'h18, 32'h2);
    wr(8'h14, 32'h0);
  endtask : t_pchg
  task t_wdt;
    int n;
    for (int c = 0; c < 2; c++) begin
      wr(8'h04, c ? 32'h09 : 32'h00);
      wr(8'h0C, 32'h80);
      wr(8'h24, 32'h1);
      wfor(2, n);
      chk("wdt_period", 1, n > (WDT << c) - 8 && n <= (WDT << c));
      rc("stat_wdt", 8'h08, 32'h08);
    end
    wdt_n = 0;
    // Base period only, so a missed clear or a live disabled watchdog shows
    wr(8'h04, 32'h00);
    repeat (4) begin
      cyc(40);
      wr(8'h24, 32'h1);
    end
    wr(8'h0C, 32'h0);
    cyc(200);
    chk("wdt_quiet", 0, wdt_n);
  endtask : t_wdt
  initial begin
    cyc(4);
    reset_n <= 1'b1;
    t_reset;
    t_timer;
    t_count;
    t_irq;
    t_sleep;
    t_pchg;
    t_wdt;
    complete_run;
  end
endmodule : test_tws_top
